// ### sep_eeprom_top.sv
`timescale 1ns/1ps
module sep_eeprom_top
    import sep_pkg::*;
#(
    parameter int P_WRITE_CYCLES = WRITE_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_wp,
    input  wire logic [2:0] i_chip_select_pins,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    output logic            o_busy
);

    // ==========================================================
    // Pin synchronisers
    logic       scl_s1_q, scl_s2_q, scl_s3_q;
    logic       sda_s1_q, sda_s2_q, sda_s3_q;
    logic       wp_s1_q, wp_s2_q;
    logic [2:0] cs_s1_q, cs_s2_q;

    // Only the second stage and later are looked at
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            wp_s1_q  <= 1'b0;
            wp_s2_q  <= 1'b0;
            cs_s1_q  <= 3'h0;
            cs_s2_q  <= 3'h0;
        end else begin
            scl_s1_q <= i_scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= i_sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            wp_s1_q  <= i_wp;
            wp_s2_q  <= wp_s1_q;
            cs_s1_q  <= i_chip_select_pins;
            cs_s2_q  <= cs_s1_q;
        end
    end

    // ==========================================================
    // Bus events
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // Both lines see equal latency, so Start and Stop stay ordered
    assign scl_rise  = scl_s2_q && !scl_s3_q;
    assign scl_fall  = !scl_s2_q && scl_s3_q;
    assign bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
    assign bus_stop  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

    // ==========================================================
    // Storage and write cycle
    sep_mem_if mif ();

    sep_store #(
        .WR_CYCLES (P_WRITE_CYCLES)
    ) u_store (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .m       (mif.store)
    );

    // ==========================================================
    // Command engine
    sep_state_t        state_q, state_d;
    logic [3:0]        cnt_q, cnt_d;
    logic [7:0]        shreg_q, shreg_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              wr_got_q, wr_got_d;
    logic              drive_q, drive_d;
    logic              buf_we_q, buf_we_d;
    logic [ADDR_W-1:0] buf_addr_q, buf_addr_d;
    logic [7:0]        buf_data_q, buf_data_d;
    logic              buf_clr_q, buf_clr_d;
    logic              commit_q, commit_d;
    logic              busy_q;
    logic              ctrl_match;

    assign mif.buf_we   = buf_we_q;
    assign mif.buf_addr = buf_addr_q;
    assign mif.buf_data = buf_data_q;
    assign mif.buf_clr  = buf_clr_q;
    assign mif.commit   = commit_q;
    assign mif.rd_addr  = addr_q;

    // Code, select pins and idle store all needed for an ack
    assign ctrl_match = (shreg_q[7:4] == CTRL_CODE)
        && (shreg_q[3:1] == cs_s2_q)
        && !mif.busy;

    // Next state of the engine
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        shreg_d    = shreg_q;
        addr_d     = addr_q;
        wr_got_d   = wr_got_q;
        drive_d    = drive_q;
        buf_we_d   = 1'b0;
        buf_addr_d = buf_addr_q;
        buf_data_d = buf_data_q;
        buf_clr_d  = 1'b0;
        commit_d   = 1'b0;
        if (bus_start) begin
            // A repeated Start drops the write, not the address
            state_d  = ST_CTRL;
            cnt_d    = CNT_ZERO;
            drive_d  = 1'b0;
            wr_got_d = 1'b0;
        end else if (bus_stop) begin
            if (state_q == ST_WDAT && wr_got_q && !wp_s2_q) begin
                commit_d = 1'b1;
            end
            // Protected: nothing committed, ready at once
            state_d = ST_IDLE;
            cnt_d   = CNT_ZERO;
            drive_d = 1'b0;
        end else if (scl_rise) begin
            unique case (state_q)
                ST_CTRL, ST_ADRH, ST_ADRL, ST_WDAT: begin
                    if (cnt_q < CNT_ACK) begin
                        shreg_d = {shreg_q[6:0], sda_s2_q};
                    end
                    if (cnt_q < CNT_END) begin
                        cnt_d = cnt_q + CNT_ONE;
                    end
                end
                ST_RDAT: begin
                    if (cnt_q == CNT_ACK && sda_s2_q) begin
                        state_d = ST_RWAIT;
                    end
                    if (cnt_q < CNT_END) begin
                        cnt_d = cnt_q + CNT_ONE;
                    end
                end
                ST_IDLE, ST_RWAIT: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_q)
                ST_CTRL: begin
                    if (cnt_q == CNT_ACK) begin
                        if (ctrl_match) begin
                            drive_d = 1'b1;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end else if (cnt_q == CNT_END) begin
                        cnt_d = CNT_ZERO;
                        if (shreg_q[0] == RW_READ) begin
                            // First read byte at the held address
                            state_d = ST_RDAT;
                            shreg_d = mif.rd_data;
                            drive_d = !mif.rd_data[7];
                            addr_d  = array_next(addr_q);
                        end else begin
                            state_d = ST_ADRH;
                            drive_d = 1'b0;
                        end
                    end
                end
                ST_ADRH: begin
                    if (cnt_q == CNT_ACK) begin
                        drive_d = 1'b1;
                        addr_d[ADDR_W-1:8] = shreg_q[ADDR_HI_W-1:0];
                    end else if (cnt_q == CNT_END) begin
                        drive_d = 1'b0;
                        cnt_d   = CNT_ZERO;
                        state_d = ST_ADRL;
                    end
                end
                ST_ADRL: begin
                    if (cnt_q == CNT_ACK) begin
                        drive_d     = 1'b1;
                        addr_d[7:0] = shreg_q;
                        buf_clr_d   = 1'b1;
                    end else if (cnt_q == CNT_END) begin
                        drive_d = 1'b0;
                        cnt_d   = CNT_ZERO;
                        state_d = ST_WDAT;
                    end
                end
                ST_WDAT: begin
                    if (cnt_q == CNT_ACK) begin
                        drive_d    = 1'b1;
                        buf_we_d   = 1'b1;
                        buf_addr_d = addr_q;
                        buf_data_d = shreg_q;
                        wr_got_d   = 1'b1;
                        // Low bits only, so the page wraps
                        addr_d = page_next(addr_q);
                    end else if (cnt_q == CNT_END) begin
                        drive_d = 1'b0;
                        cnt_d   = CNT_ZERO;
                    end
                end
                ST_RDAT: begin
                    if (cnt_q >= CNT_ONE && cnt_q < CNT_ACK) begin
                        // Open drain: a one is sent by releasing
                        drive_d = !shreg_q[6];
                        shreg_d = {shreg_q[6:0], 1'b0};
                    end else if (cnt_q == CNT_ACK) begin
                        drive_d = 1'b0;
                    end else if (cnt_q == CNT_END) begin
                        // Master acked: next byte goes out
                        cnt_d   = CNT_ZERO;
                        shreg_d = mif.rd_data;
                        drive_d = !mif.rd_data[7];
                        addr_d  = array_next(addr_q);
                    end
                end
                ST_RWAIT: begin
                    drive_d = 1'b0;
                end
                ST_IDLE: begin
                end
            endcase
        end
    end

    // Registers of the engine and the pin drivers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q    <= ST_IDLE;
            cnt_q      <= CNT_ZERO;
            shreg_q    <= 8'h00;
            addr_q     <= '0;
            wr_got_q   <= 1'b0;
            drive_q    <= 1'b0;
            buf_we_q   <= 1'b0;
            buf_addr_q <= '0;
            buf_data_q <= 8'h00;
            buf_clr_q  <= 1'b0;
            commit_q   <= 1'b0;
            busy_q     <= 1'b0;
            o_sda      <= 1'b0;
            o_sda_oe_n <= 1'b1;
            o_busy     <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            shreg_q    <= shreg_d;
            addr_q     <= addr_d;
            wr_got_q   <= wr_got_d;
            drive_q    <= drive_d;
            buf_we_q   <= buf_we_d;
            buf_addr_q <= buf_addr_d;
            buf_data_q <= buf_data_d;
            buf_clr_q  <= buf_clr_d;
            commit_q   <= commit_d;
            busy_q     <= mif.busy;
            o_sda      <= 1'b0;
            o_sda_oe_n <= !drive_d;
            o_busy     <= busy_q;
        end
    end

endmodule

// ### sep_pkg.sv
package sep_pkg;

    // ==========================================================
    // Array geometry
    localparam int PAGE_BYTES = 32;
    localparam int MEM_BYTES  = 4096;
    localparam int ADDR_W     = $clog2(MEM_BYTES);
    localparam int PAGE_W     = $clog2(PAGE_BYTES);
    localparam int ADDR_HI_W  = ADDR_W - 8;

    // ==========================================================
    // Control byte
    localparam logic [3:0] CTRL_CODE = 4'ha;
    localparam logic       RW_READ   = 1'b1;

    // ==========================================================
    // Bit counter marks within one nine-clock byte slot
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE  = 4'h1;
    localparam logic [3:0] CNT_ACK  = 4'h8;
    localparam logic [3:0] CNT_END  = 4'h9;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int WRITE_CYCLES  =
        (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Command engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CTRL,
        ST_ADRH,
        ST_ADRL,
        ST_WDAT,
        ST_RDAT,
        ST_RWAIT
    } sep_state_t;

    // Next address inside the same page, upper bits held
    function automatic logic [ADDR_W-1:0] page_next(
        input logic [ADDR_W-1:0] a);
        logic [PAGE_W-1:0] low;
        low = a[PAGE_W-1:0] + {{(PAGE_W-1){1'b0}}, 1'b1};
        return {a[ADDR_W-1:PAGE_W], low};
    endfunction

    // Next address over the whole array, wrapping to zero
    function automatic logic [ADDR_W-1:0] array_next(
        input logic [ADDR_W-1:0] a);
        return a + {{(ADDR_W-1){1'b0}}, 1'b1};
    endfunction

endpackage

// ### sep_mem_if.sv
`timescale 1ns/1ps
interface sep_mem_if;
    import sep_pkg::*;

    logic              buf_we;
    logic [ADDR_W-1:0] buf_addr;
    logic [7:0]        buf_data;
    logic              buf_clr;
    logic              commit;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0]        rd_data;
    logic              busy;

    modport engine (
        output buf_we,
        output buf_addr,
        output buf_data,
        output buf_clr,
        output commit,
        output rd_addr,
        input  rd_data,
        input  busy
    );

    modport store (
        input  buf_we,
        input  buf_addr,
        input  buf_data,
        input  buf_clr,
        input  commit,
        input  rd_addr,
        output rd_data,
        output busy
    );
endinterface

// ### sep_store.sv
`timescale 1ns/1ps
module sep_store
    import sep_pkg::*;
#(
    parameter int WR_CYCLES = WRITE_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    sep_mem_if.store  m
);
    localparam int TMR_W = $clog2(WR_CYCLES + 1);

    logic [7:0]            mem  [MEM_BYTES];
    logic [7:0]            pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q, mask_d;
    logic [ADDR_W-PAGE_W-1:0] base_q, base_d;
    logic                  busy_q, busy_d;
    logic                  cpy_q, cpy_d;
    logic [PAGE_W-1:0]     idx_q, idx_d;
    logic [TMR_W-1:0]      tmr_q, tmr_d;
    logic [7:0]            rd_q;
    logic                  mem_we;
    logic [ADDR_W-1:0]     mem_wa;

    assign m.rd_data = rd_q;
    assign m.busy    = busy_q;

    // ==========================================================
    // Page buffer capture and self-timed write cycle
    always_comb begin
        mask_d = mask_q;
        base_d = base_q;
        busy_d = busy_q;
        cpy_d  = cpy_q;
        idx_d  = idx_q;
        tmr_d  = tmr_q;
        mem_we = 1'b0;
        mem_wa = {base_q, idx_q};
        if (m.buf_clr) begin
            mask_d = '0;
        end
        if (m.buf_we) begin
            // Later bytes to the same slot simply overwrite
            mask_d[m.buf_addr[PAGE_W-1:0]] = 1'b1;
            base_d = m.buf_addr[ADDR_W-1:PAGE_W];
        end
        if (m.commit) begin
            busy_d = 1'b1;
            cpy_d  = 1'b1;
            idx_d  = '0;
            tmr_d  = TMR_W'(WR_CYCLES - 1);
        end else if (busy_q) begin
            // Only slots that were written reach the array
            mem_we = cpy_q && mask_q[idx_q];
            if (cpy_q) begin
                idx_d = idx_q + {{(PAGE_W-1){1'b0}}, 1'b1};
                if (idx_q == PAGE_W'(PAGE_BYTES - 1)) begin
                    cpy_d  = 1'b0;
                    mask_d = '0;
                end
            end
            if (tmr_q == '0) begin
                busy_d = 1'b0;
            end else begin
                tmr_d = tmr_q - {{(TMR_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Arrays carry no reset; the mask alone says what is valid
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mask_q <= '0;
            base_q <= '0;
            busy_q <= 1'b0;
            cpy_q  <= 1'b0;
            idx_q  <= '0;
            tmr_q  <= '0;
        end else begin
            mask_q <= mask_d;
            base_q <= base_d;
            busy_q <= busy_d;
            cpy_q  <= cpy_d;
            idx_q  <= idx_d;
            tmr_q  <= tmr_d;
        end
        if (m.buf_we) begin
            pbuf[m.buf_addr[PAGE_W-1:0]] <= m.buf_data;
        end
        if (mem_we) begin
            mem[mem_wa] <= pbuf[idx_q];
        end
        rd_q <= mem[m.rd_addr];
    end
endmodule

// ### sep_i2c_master.sv
`timescale 1ns/1ps
// ==========================================================
// Bus master model: quarter-bit steps, 320 ns bit period
module sep_i2c_master (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    localparam int Q = 80;

    // Idle bus: clock stands high, data released to pull-up
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    // Data changes only while the clock is low
    task automatic bit_out(input logic b);
        #Q o_sda_low = !b;
        #Q o_scl = 1'b1;
        #(2*Q) o_scl = 1'b0;
    endtask

    // Released line is sampled in mid-high
    task automatic bit_in(output logic b);
        #Q o_sda_low = 1'b0;
        #Q o_scl = 1'b1;
        #Q b = i_sda;
        #Q o_scl = 1'b0;
    endtask

    // Also serves as repeated start and as a poll start
    task automatic start();
        if (!o_scl) begin
            #Q o_sda_low = 1'b0;
            #Q o_scl = 1'b1;
        end
        #Q o_sda_low = 1'b1;
        #Q o_scl = 1'b0;
    endtask

    task automatic stop();
        #Q o_sda_low = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_low = 1'b0;
        #Q;
    endtask

    // Bytes go out most significant bit first
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = !b;
    endtask

    // Last byte of a read is closed by withholding ack
    task automatic rbyte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(!ack);
    endtask
endmodule

// ### sep_eeprom_properties.sv
`timescale 1ns/1ps
module sep_eeprom_checker
    import sep_pkg::*;
#(
    parameter int P_WRITE_CYCLES = WRITE_CYCLES
) (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       i_wp,
    input wire logic [2:0] i_chip_select_pins,
    input wire logic       o_sda,
    input wire logic       o_sda_oe_n,
    input wire logic       o_busy
);
    // ==========================================================
    // Helper state: pin history, time since Stop, busy length
    logic        scl_q, scl_d, sda_q, sda_d;
    logic [7:0]  since_stop_q, since_stop_d;
    logic [31:0] busy_len_q, busy_len_d;

    // Stop seen on raw pins; counter saturates to stay small
    always_comb begin
        scl_d        = i_scl;
        sda_d        = i_sda;
        since_stop_d = since_stop_q;
        if (scl_q && i_scl && !sda_q && i_sda) begin
            since_stop_d = 8'h00;
        end else if (since_stop_q != 8'hff) begin
            since_stop_d = since_stop_q + 8'h01;
        end
        busy_len_d = o_busy ? busy_len_q + 32'h1 : 32'h0;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            scl_q        <= 1'b1;
            sda_q        <= 1'b1;
            since_stop_q <= 8'hff;
            busy_len_q   <= 32'h0;
        end else begin
            scl_q        <= scl_d;
            sda_q        <= sda_d;
            since_stop_q <= since_stop_d;
            busy_len_q   <= busy_len_d;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_low_bit;
        !o_sda_oe_n [*7];
    endsequence

    sequence s_high_hold;
        $stable(o_sda_oe_n) [*3];
    endsequence

    a_sda_zero: assert property (o_sda == 1'b0)
        else $error("data output not low");
    a_busy_noack: assert property ($fell(o_sda_oe_n) |-> ##3 !o_busy)
        else $error("acknowledge during write cycle");
    a_busy_length: assert property (
        $fell(o_busy) |-> busy_len_q == P_WRITE_CYCLES)
        else $error("write cycle length wrong");
    a_busy_bound: assert property (busy_len_q <= P_WRITE_CYCLES)
        else $error("write cycle overruns");
    a_busy_after_stop: assert property (
        $rose(o_busy) |-> since_stop_q <= 8'h08)
        else $error("write cycle without Stop");
    a_wp_no_cycle: assert property (
        $rose(o_busy) |-> !$past(i_wp, 8))
        else $error("write cycle while protected");
    a_bit_hold: assert property ($fell(o_sda_oe_n) |-> s_low_bit)
        else $error("pulled bit too short");
    a_high_stable: assert property (
        $rose(i_scl) |-> ##1 s_high_hold)
        else $error("data moved while clock high");
endmodule

bind sep_eeprom_top sep_eeprom_checker #(
    .P_WRITE_CYCLES(P_WRITE_CYCLES)
) u_chk (
    .i_clk              (i_clk),
    .i_rst_n            (i_rst_n),
    .i_scl              (i_scl),
    .i_sda              (i_sda),
    .i_wp               (i_wp),
    .i_chip_select_pins (i_chip_select_pins),
    .o_sda              (o_sda),
    .o_sda_oe_n         (o_sda_oe_n),
    .o_busy             (o_busy)
);

// ### sep_eeprom_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("[ERR] %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module sep_eeprom_tb_top;
    import sep_pkg::*;
    // Long enough that the first poll still finds the cycle running
    localparam int         WRC  = 128;
    localparam logic [2:0] PINS = 3'h5;
    localparam logic [7:0] CW   = {CTRL_CODE, PINS, 1'b0};

    logic       i_clk, i_rst_n, i_wp, scl, sda_low, sda;
    logic       o_sda, o_sda_oe_n, o_busy;
    logic [2:0] pins;
    logic [7:0] mdl [0:MEM_BYTES-1];
    int         n_fail, checked;

    // Resolved wire with pull-up
    assign sda = sda_low ? 1'b0 : (!o_sda_oe_n ? o_sda : 1'b1);

    sep_eeprom_top #(.P_WRITE_CYCLES(WRC)) dut (
        .i_clk              (i_clk),
        .i_rst_n            (i_rst_n),
        .i_scl              (scl),
        .i_sda              (sda),
        .i_wp               (i_wp),
        .i_chip_select_pins (pins),
        .o_sda              (o_sda),
        .o_sda_oe_n         (o_sda_oe_n),
        .o_busy             (o_busy)
    );

    sep_i2c_master mst (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));

    // ==========================================================
    // Clock and closing
    initial i_clk = 1'b0;
    always #20 i_clk = ~i_clk;

    task automatic final_report();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Bus sequences
    task automatic send_hdr(input logic [ADDR_W-1:0] a);
        logic k;
        mst.start();
        mst.wbyte(CW, k);
        `CHK("ctrl ack", 1'b1, k)
        mst.wbyte({{(16-ADDR_W){1'b0}}, a[ADDR_W-1:8]}, k);
        `CHK("addr hi ack", 1'b1, k)
        mst.wbyte(a[7:0], k);
        `CHK("addr lo ack", 1'b1, k)
    endtask

    // Model wraps inside the page; protected writes leave it alone
    task automatic page_wr(input logic [ADDR_W-1:0] a0, input int n,
                           input logic [7:0] v);
        logic              k;
        logic [ADDR_W-1:0] a;
        a = a0;
        send_hdr(a0);
        for (int j = 0; j < n; j++) begin
            mst.wbyte(v + j[7:0], k);
            `CHK("data ack", 1'b1, k)
            if (!i_wp) mdl[a] = v + j[7:0];
            a = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
        end
        mst.stop();
        mst.start();
        mst.wbyte(CW, k);
        `CHK("poll at once", i_wp, k)
        `CHK("busy flag", !i_wp, o_busy)
        for (int j = 0; j < 20 && !k; j++) begin
            mst.start();
            mst.wbyte(CW, k);
        end
        mst.stop();
        `CHK("write done", 1'b1, k)
        `CHK("busy over", 1'b0, o_busy)
    endtask

    // Random read when rnd is set, otherwise current-address read
    task automatic rd_seq(input logic [ADDR_W-1:0] a0, input int n,
                          input logic rnd);
        logic              k;
        logic [7:0]        d;
        logic [ADDR_W-1:0] a;
        a = a0;
        if (rnd) send_hdr(a0);
        mst.start();
        mst.wbyte({CTRL_CODE, PINS, RW_READ}, k);
        `CHK("read ctrl ack", 1'b1, k)
        for (int j = 0; j < n; j++) begin
            mst.rbyte(j != n - 1, d);
            `CHK("read data", mdl[a], d)
            a = a + 1'b1;
        end
        // Whole clock periods keep the bus off the sampling edge
        #120;
        `CHK("released", 1'b1, o_sda_oe_n)
        mst.stop();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_fill();
        page_wr(12'h000, 32, 8'h40);
        page_wr(12'h010, 2, 8'hc0);
        rd_seq(12'h000, 32, 1'b1);
        rd_seq(12'h011, 1, 1'b1);
        rd_seq(12'h012, 1, 1'b0);
    endtask

    task automatic t_wp();
        @(posedge i_clk);
        #5 i_wp = 1'b1;
        page_wr(12'h005, 1, 8'h5a);
        @(posedge i_clk);
        #5 i_wp = 1'b0;
        rd_seq(12'h005, 1, 1'b1);
    endtask

    // Wrong type code, then chip-select mismatches
    task automatic t_select();
        logic [7:0] bad [3];
        logic       k;
        bad = '{{4'hb, PINS, 1'b0}, {CTRL_CODE, PINS ^ 3'h1, 1'b0},
                {CTRL_CODE, PINS ^ 3'h4, 1'b1}};
        foreach (bad[i]) begin
            mst.start();
            mst.wbyte(bad[i], k);
            `CHK("foreign ctrl", 1'b0, k)
            mst.stop();
        end
    endtask

    // 34 bytes into one page: first two slots overwritten
    task automatic t_wrap();
        page_wr(12'h022, 34, 8'h80);
        rd_seq(12'h024, 1, 1'b0);
        rd_seq(12'h020, 32, 1'b1);
    endtask

    task automatic t_top();
        page_wr(12'hfff, 1, 8'h3c);
        rd_seq(12'hfff, 2, 1'b1);
        rd_seq(12'h001, 1, 1'b0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        n_fail  = 0;
        checked = 0;
        i_rst_n = 1'b0;
        i_wp    = 1'b0;
        pins    = PINS;
        repeat (6) @(posedge i_clk);
        #5 i_rst_n = 1'b1;
        repeat (6) @(posedge i_clk);
        // Bus moves just after the edge, never on it
        #5;
        t_fill();
        t_wp();
        t_select();
        t_wrap();
        t_top();
        final_report();
    end

    // Whole run needs about 0.56 ms of bus traffic
    initial begin
        #3000000;
        n_fail++;
        $display("[ERR] watchdog exp done got hang");
        final_report();
    end
endmodule
